// file: tksoc_pkg.sv
/*
 * Shared constants for the touch key scan and output control block:
 * time base figures, scan periods, APB register map and field layout.
 * Assumes a 125 MHz core clock and a one millisecond internal time base.
 */
package tksoc_pkg;

    // core clock rate and the derived millisecond tick
    localparam int unsigned CLK_HZ        = 125_000_000;
    localparam int unsigned TICK_HZ       = 1_000;
    localparam int unsigned TICK_CYCLES   = CLK_HZ / TICK_HZ;

    // all scan, idle and timeout counters run in milliseconds
    localparam int unsigned CNT_W         = 17;
    localparam logic [16:0] INIT_MS       = 17'h001F4; // 500 ms
    localparam logic [16:0] FAST_MS       = 17'h00010; // 16 ms
    localparam logic [16:0] SLOW_SHORT_MS = 17'h00020; // 32 ms
    localparam logic [16:0] SLOW_LONG_MS  = 17'h00080; // 128 ms
    localparam logic [16:0] IDLE_MS       = 17'h01F40; // 8 s
    localparam logic [16:0] RESP_MIN_MS   = 17'h00022; // 34 ms
    localparam logic [16:0] HOLD_SHORT_MS = 17'h03E80; // 16 s
    localparam logic [16:0] HOLD_LONG_MS  = 17'h186A0; // 100 s

    // APB register map, byte addresses
    localparam int unsigned ADDR_W        = 8;
    localparam logic [7:0]  REG_CFG       = 8'h00;
    localparam logic [7:0]  REG_STAT      = 8'h04;
    localparam logic [7:0]  REG_SCANS     = 8'h08;

    // configuration register fields
    localparam int unsigned CFG_SCAN_LSB  = 0;
    localparam int unsigned CFG_HOLD_BIT  = 2;
    localparam int unsigned CFG_OD_BIT    = 3;
    localparam int unsigned CFG_NSTR_BIT  = 4;
    localparam int unsigned CFG_W         = 5;
    localparam logic [4:0]  CFG_RST       = 5'h02;

    // scan option codes in the configuration register
    localparam logic [1:0]  SCAN_FAST_ONLY  = 2'h0;
    localparam logic [1:0]  SCAN_SLOW_SHORT = 2'h1;
    localparam logic [1:0]  SCAN_SLOW_LONG  = 2'h2;

    // status register fields
    localparam int unsigned ST_INIT_DONE  = 0;
    localparam int unsigned ST_SLOW       = 1;
    localparam int unsigned ST_TOUCH      = 2;
    localparam int unsigned ST_ACTIVE     = 3;
    localparam int unsigned ST_POL        = 4;
    localparam int unsigned ST_TGL        = 5;
    localparam int unsigned ST_LOCK       = 6;
    localparam int unsigned ST_STRAPS     = 7;

    typedef enum logic [1:0] {MODE_INIT, MODE_FAST, MODE_SLOW} tksoc_mode_t;
    typedef enum logic [1:0] {DET_IDLE, DET_QUAL, DET_TOUCH, DET_LOCK}
        tksoc_det_t;

endpackage

// file: tksoc_top.sv
/*
 * Touch key scan scheduler and output control with an APB register port.
 * Holds the power-on initialisation, fast and slow scan scheduling, touch
 * qualification, key-on timeout, strap latching and output pin shaping.
 * Assumes the analog front end answers each scan strobe with a touch level
 * on sense_hit_i (asynchronous, synchronised here) and that the host reads
 * the output pin; reset_i stands for power-on.
 */
// Overview of operation
// [RULE_01] after power-on, 500 ms initialisation; no touch decision, no touch shown
// [RULE_02] leaving initialisation, start fast scan with a 16 ms period
// [RULE_03] two-mode options: 8 s without touch in fast scan enters slow scan
// [RULE_04] a touch seen on a slow scan returns to fast scan at once
// [RULE_05] long slow option scans every 128 ms
// [RULE_06] short slow option scans every 32 ms
// [RULE_07] fast-only option never enters slow scan
// [RULE_08] fast scan response from touch onset stays within about 48 ms
// [RULE_09] slow 128 ms scan response stays within about 160 ms
// [RULE_10] slow 32 ms scan response stays within about 64 ms
// [RULE_11] response is never shorter than 34 ms in any mode
// [RULE_12] straps sampled once at power-on and held; later changes ignored
// [RULE_13] push-pull direct: active high if polarity floats, else active low
// [RULE_14] push-pull toggle: starts low if polarity floats, high if tied high
// [RULE_15] open-drain: direct active low, or toggle starting released
// [RULE_16] open-drain output ignores the polarity strap
// [RULE_17] a strap found tied high has its pull-down switched off
// [RULE_18] strapless parts: fixed direct output, high or pulled low when active
// [RULE_19] 16 s option: touch held longer is released until a new touch
// [RULE_20] 100 s option: touch held longer is released until a new touch
// [RULE_21] direct mode shows the active level exactly while touch is asserted
// [RULE_22] toggle mode inverts once per new touch; releases leave it alone
// [RULE_23] scan, idle and timeout times count one ms time base, cleared at reset
`timescale 1ns/1ps
module tksoc_top #(
    parameter int unsigned TICK_CYCLES = tksoc_pkg::TICK_CYCLES // ms tick
) (
    input  wire logic        core_clk_i,                 // 125 MHz clock
    input  wire logic        reset_i,                    // power-on reset
    input  wire logic        psel_i,                     // apb select
    input  wire logic        penable_i,                  // apb enable
    input  wire logic        pwrite_i,                   // apb write
    input  wire logic [7:0]  paddr_i,                    // apb byte address
    input  wire logic [31:0] pwdata_i,                   // apb write data
    output logic      [31:0] prdata_o,                   // apb read data
    output logic             pready_o,                   // apb ready
    output logic             pslverr_o,                  // apb error
    input  wire logic        polarity_select_strap_i,    // polarity strap pin
    input  wire logic        latch_mode_select_strap_i,  // latch mode strap pin
    input  wire logic        sense_hit_i,                // front end touch level
    output logic             scan_start_o,               // scan strobe, 1 cycle
    output logic             pd_en_polarity_o,           // polarity pull-down on
    output logic             pd_en_latch_o,              // latch strap pull-down
    output logic             out_o,                      // output pin level
    output logic             out_oe_o                    // output pin enable
);

    localparam logic [16:0] TICK_LAST = 17'(TICK_CYCLES - 1);

    // synchroniser stages for the three pin inputs
    logic [2:0]  pin_meta_q;
    logic [2:0]  pin_sync_q;
    logic        pol_s;
    logic        tgl_s;
    logic        sense_s;

    // time base
    logic [16:0] tick_cnt_q;
    logic        tick_q;

    // strap latch
    logic        straps_done_q;
    logic        pol_strap_q;
    logic        tgl_strap_q;

    // scan scheduling
    tksoc_pkg::tksoc_mode_t mode_q;
    logic [16:0] init_cnt_q;
    logic [16:0] period_cnt_q;
    logic [16:0] idle_cnt_q;
    logic [16:0] slow_ms;
    logic        slow_allowed;
    logic        scan_q;
    logic        hit;
    logic        miss;
    logic [31:0] scan_count_q;

    // touch detection
    tksoc_pkg::tksoc_det_t det_q;
    logic [16:0] det_cnt_q;
    logic [16:0] hold_ms;
    logic        touch;
    logic        toggle_q;

    // output shaping
    logic        use_pol;
    logic        use_tgl;
    logic        asserted;
    logic        out_q;
    logic        out_oe_q;

    // configuration and bus
    logic [4:0]  cfg_q;
    logic [1:0]  cfg_scan;
    logic        cfg_hold_long;
    logic        cfg_od;
    logic        cfg_nostrap;
    logic        pready_q;
    logic        pslverr_q;
    logic [31:0] prdata_q;
    logic        setup;
    logic [31:0] rd_data;
    logic        rd_hit;

    // two flip-flop synchronisers; only the second stage is read
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            pin_meta_q <= 3'h0;
            pin_sync_q <= 3'h0;
        end else begin
            pin_meta_q <= {sense_hit_i, latch_mode_select_strap_i,
                           polarity_select_strap_i};
            pin_sync_q <= pin_meta_q;
        end
    end

    assign pol_s   = pin_sync_q[0];
    assign tgl_s   = pin_sync_q[1];
    assign sense_s = pin_sync_q[2];

    // millisecond time base feeding every timed counter
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            tick_cnt_q <= 17'h00000;                          // [RULE_23]
            tick_q     <= 1'b0;
        end else if (tick_cnt_q >= TICK_LAST) begin
            tick_cnt_q <= 17'h00000;
            tick_q     <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 17'h00001;
            tick_q     <= 1'b0;
        end
    end

    // configuration fields
    assign cfg_scan      = cfg_q[tksoc_pkg::CFG_SCAN_LSB +: 2];
    assign cfg_hold_long = cfg_q[tksoc_pkg::CFG_HOLD_BIT];
    assign cfg_od        = cfg_q[tksoc_pkg::CFG_OD_BIT];
    assign cfg_nostrap   = cfg_q[tksoc_pkg::CFG_NSTR_BIT];

    // straps caught once, on the first tick after release of reset
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            straps_done_q <= 1'b0;
            pol_strap_q   <= 1'b0;
            tgl_strap_q   <= 1'b0;
        end else if (tick_q && !straps_done_q) begin
            straps_done_q <= 1'b1;                            // [RULE_12]
            pol_strap_q   <= pol_s;
            tgl_strap_q   <= tgl_s;
        end
    end

    // pull-downs stay on until a strap is seen tied high
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            pd_en_polarity_o <= 1'b1;
            pd_en_latch_o    <= 1'b1;
        end else begin
            pd_en_polarity_o <= !(straps_done_q && pol_strap_q); // [RULE_17]
            pd_en_latch_o    <= !(straps_done_q && tgl_strap_q); // [RULE_17]
        end
    end

    // slow period and whether slow scan exists at all
    always_comb begin
        slow_allowed = 1'b1;
        slow_ms      = tksoc_pkg::SLOW_LONG_MS;               // [RULE_05]
        unique case (cfg_scan)
            tksoc_pkg::SCAN_SLOW_SHORT: slow_ms = tksoc_pkg::SLOW_SHORT_MS; // [RULE_06]
            tksoc_pkg::SCAN_SLOW_LONG:  slow_ms = tksoc_pkg::SLOW_LONG_MS;
            default:                    slow_allowed = 1'b0;   // [RULE_07]
        endcase
    end

    // scan outcome, valid in the cycle of the scan strobe
    assign hit  = scan_q && sense_s;
    assign miss = scan_q && !sense_s;

    // scan mode sequence: init, fast, slow
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            mode_q <= tksoc_pkg::MODE_INIT;
        end else begin
            unique case (mode_q)
                tksoc_pkg::MODE_INIT:
                    if (tick_q && init_cnt_q >= tksoc_pkg::INIT_MS - 17'h00001)
                        mode_q <= tksoc_pkg::MODE_FAST;       // [RULE_02]
                tksoc_pkg::MODE_FAST:
                    if (slow_allowed && !hit && !touch &&
                        idle_cnt_q >= tksoc_pkg::IDLE_MS)
                        mode_q <= tksoc_pkg::MODE_SLOW;       // [RULE_03]
                tksoc_pkg::MODE_SLOW:
                    if (hit || !slow_allowed)
                        mode_q <= tksoc_pkg::MODE_FAST;       // [RULE_04]
                default:
                    mode_q <= tksoc_pkg::MODE_INIT;
            endcase
        end
    end

    // initialisation timer, 500 ms of ticks
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            init_cnt_q <= 17'h00000;
        end else if (mode_q == tksoc_pkg::MODE_INIT && tick_q) begin
            init_cnt_q <= init_cnt_q + 17'h00001;             // [RULE_01]
        end
    end

    // fast-mode idle time; any hit or held touch restarts it
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            idle_cnt_q <= 17'h00000;
        end else if (mode_q != tksoc_pkg::MODE_FAST || hit || touch) begin
            idle_cnt_q <= 17'h00000;                          // [RULE_03]
        end else if (tick_q && idle_cnt_q < tksoc_pkg::IDLE_MS) begin
            idle_cnt_q <= idle_cnt_q + 17'h00001;
        end
    end

    // scan period counter and strobe; a hit on a slow scan restarts the period
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            period_cnt_q <= 17'h00000;
            scan_q       <= 1'b0;
        end else if (mode_q == tksoc_pkg::MODE_INIT ||
                     (mode_q == tksoc_pkg::MODE_SLOW && hit)) begin
            period_cnt_q <= 17'h00000;                        // [RULE_04]
            scan_q       <= 1'b0;
        end else if (tick_q) begin
            if (period_cnt_q >= ((mode_q == tksoc_pkg::MODE_SLOW) ?
                                 slow_ms : tksoc_pkg::FAST_MS) - 17'h00001) begin
                period_cnt_q <= 17'h00000;                    // [RULE_02]
                scan_q       <= 1'b1;
            end else begin
                period_cnt_q <= period_cnt_q + 17'h00001;
                scan_q       <= 1'b0;
            end
        end else begin
            scan_q <= 1'b0;
        end
    end

    assign scan_start_o = scan_q;

    // running count of scans, readable by software
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            scan_count_q <= 32'h00000000;
        end else if (scan_q) begin
            scan_count_q <= scan_count_q + 32'h00000001;
        end
    end

    // key-on limit
    assign hold_ms = cfg_hold_long ? tksoc_pkg::HOLD_LONG_MS   // [RULE_20]
                                   : tksoc_pkg::HOLD_SHORT_MS; // [RULE_19]

    // touch qualification, hold timeout and lockout
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            det_q     <= tksoc_pkg::DET_IDLE;
            det_cnt_q <= 17'h00000;
        end else begin
            unique case (det_q)
                tksoc_pkg::DET_IDLE: begin
                    det_cnt_q <= 17'h00000;
                    if (hit)
                        det_q <= tksoc_pkg::DET_QUAL;
                end
                tksoc_pkg::DET_QUAL: begin
                    // every scan inside the window must see the touch
                    if (miss) begin
                        det_q <= tksoc_pkg::DET_IDLE;
                    end else if (det_cnt_q >= tksoc_pkg::RESP_MIN_MS) begin
                        det_q     <= tksoc_pkg::DET_TOUCH;    // [RULE_11]
                        det_cnt_q <= 17'h00000;
                    end else if (tick_q) begin
                        det_cnt_q <= det_cnt_q + 17'h00001;   // [RULE_08]
                    end
                end
                tksoc_pkg::DET_TOUCH: begin
                    if (miss) begin
                        det_q <= tksoc_pkg::DET_IDLE;
                    end else if (det_cnt_q >= hold_ms) begin
                        det_q <= tksoc_pkg::DET_LOCK;         // [RULE_19]
                    end else if (tick_q) begin
                        det_cnt_q <= det_cnt_q + 17'h00001;
                    end
                end
                tksoc_pkg::DET_LOCK: begin
                    // held until the key is seen lifted
                    if (miss)
                        det_q <= tksoc_pkg::DET_IDLE;         // [RULE_20]
                end
                default:
                    det_q <= tksoc_pkg::DET_IDLE;
            endcase
        end
    end

    // slow scans reach qualification via the immediate fast return
    assign touch = (det_q == tksoc_pkg::DET_TOUCH);           // [RULE_09] [RULE_10]

    // toggle state flips once on each new touch
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            toggle_q <= 1'b0;
        end else if (det_q == tksoc_pkg::DET_QUAL && !miss &&
                     det_cnt_q >= tksoc_pkg::RESP_MIN_MS) begin
            toggle_q <= !toggle_q;                            // [RULE_22]
        end
    end

    // effective output mode from straps and variant
    assign use_tgl  = !cfg_nostrap && tgl_strap_q;             // [RULE_18]
    assign use_pol  = !cfg_nostrap && !cfg_od && pol_strap_q;  // [RULE_16]
    assign asserted = use_tgl ? toggle_q : touch;              // [RULE_21]

    // pin drive: push-pull level or open-drain pull-low
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            out_q    <= 1'b0;
            out_oe_q <= 1'b0;
        end else if (!straps_done_q) begin
            out_q    <= 1'b0;                                 // [RULE_01]
            out_oe_q <= 1'b0;
        end else if (cfg_od) begin
            out_q    <= 1'b0;                                 // [RULE_15]
            out_oe_q <= asserted;
        end else begin
            out_q    <= asserted ^ use_pol;                   // [RULE_13] [RULE_14]
            out_oe_q <= 1'b1;
        end
    end

    assign out_o    = out_q;
    assign out_oe_o = out_oe_q;

    // apb: answer in the first access cycle
    assign setup = psel_i && !penable_i;

    // read mux over the register map
    always_comb begin
        rd_data = 32'h00000000;
        rd_hit  = 1'b1;
        unique case (paddr_i)
            tksoc_pkg::REG_CFG:   rd_data[tksoc_pkg::CFG_W-1:0] = cfg_q;
            tksoc_pkg::REG_STAT: begin
                rd_data[tksoc_pkg::ST_INIT_DONE] =
                    (mode_q != tksoc_pkg::MODE_INIT);
                rd_data[tksoc_pkg::ST_SLOW]   = (mode_q == tksoc_pkg::MODE_SLOW);
                rd_data[tksoc_pkg::ST_TOUCH]  = touch;
                rd_data[tksoc_pkg::ST_ACTIVE] = asserted;
                rd_data[tksoc_pkg::ST_POL]    = pol_strap_q;
                rd_data[tksoc_pkg::ST_TGL]    = tgl_strap_q;
                rd_data[tksoc_pkg::ST_LOCK]   = (det_q == tksoc_pkg::DET_LOCK);
                rd_data[tksoc_pkg::ST_STRAPS] = straps_done_q;
            end
            tksoc_pkg::REG_SCANS: rd_data = scan_count_q;
            default:              rd_hit  = 1'b0;
        endcase
    end

    // configuration register, written on the access edge
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cfg_q <= tksoc_pkg::CFG_RST;
        end else if (psel_i && penable_i && pready_q && pwrite_i &&
                     paddr_i == tksoc_pkg::REG_CFG) begin
            cfg_q <= pwdata_i[tksoc_pkg::CFG_W-1:0];
        end
    end

    // ready, error and read data prepared during setup
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h00000000;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup && !rd_hit;
            prdata_q  <= (setup && !pwrite_i && rd_hit) ? rd_data
                                                        : 32'h00000000;
        end
    end

    assign pready_o  = pready_q;
    assign pslverr_o = pslverr_q;
    assign prdata_o  = prdata_q;

endmodule

// file: tksoc_sva.sv
/*
 * Port checker for the touch key block.
 * Bound onto tksoc_top; one clock, async high reset.
 */
`timescale 1ns/1ps
module tksoc_sva #(
    parameter int unsigned TICK_CYCLES = 125000 // cycles per ms tick
) (
    input wire logic       core_clk_i,                // clock
    input wire logic       reset_i,                   // power-on reset
    input wire logic       psel_i,                    // apb select
    input wire logic       penable_i,                 // apb enable
    input wire logic [7:0] paddr_i,                   // apb address
    input wire logic       pready_o,                  // apb ready
    input wire logic       pslverr_o,                 // apb error
    input wire logic       polarity_select_strap_i,   // polarity strap
    input wire logic       latch_mode_select_strap_i, // latch strap
    input wire logic       scan_start_o,              // scan strobe
    input wire logic       pd_en_polarity_o,          // polarity pull-down
    input wire logic       pd_en_latch_o,             // latch pull-down
    input wire logic       out_o,                     // pin level
    input wire logic       out_oe_o                   // pin enable
);
    localparam int unsigned INIT_CY = 500 * TICK_CYCLES - 2;
    localparam int unsigned GAP_LO  = 16 * TICK_CYCLES - 1;
    localparam int unsigned GAP_HI  = 128 * TICK_CYCLES - 1;
    int unsigned up_q;
    int unsigned gap_q;
    logic        seen_q;
    logic        mapped;

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    // register map hit
    assign mapped = paddr_i inside {tksoc_pkg::REG_CFG, tksoc_pkg::REG_STAT,
                                    tksoc_pkg::REG_SCANS};

    // cycles since reset and since the last scan
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            up_q   <= 0;
            gap_q  <= 0;
            seen_q <= 1'b0;
        end else begin
            up_q   <= (up_q < INIT_CY + 64) ? up_q + 1 : up_q;
            gap_q  <= scan_start_o ? 0 : gap_q + 1;
            seen_q <= seen_q | scan_start_o;
        end
    end

    sequence setup_s;
        psel_i && !penable_i;
    endsequence

    chk_ready_setup:
        assert property (setup_s |=> pready_o)
        else $error("no ready after setup");
    chk_ready_only:
        assert property (!(psel_i && !penable_i) |=> !pready_o)
        else $error("ready without setup");
    chk_err_unmapped:
        assert property (setup_s ##0 !mapped |=> pslverr_o && pready_o)
        else $error("no error, unmapped");
    chk_err_mapped:
        assert property (setup_s ##0 mapped |=> !pslverr_o)
        else $error("error, mapped");
    chk_scan_pulse:
        assert property (scan_start_o |=> !scan_start_o)
        else $error("scan strobe too long");
    chk_init_noscan:
        assert property (scan_start_o |-> up_q >= INIT_CY)
        else $error("scan during init");
    chk_init_quiet:
        assert property (up_q > 20 && up_q < INIT_CY |->
                         $stable(out_o) && $stable(out_oe_o))
        else $error("out moved in init");
    chk_scan_gap:
        assert property (scan_start_o && seen_q |->
                         gap_q >= GAP_LO && gap_q <= GAP_HI)
        else $error("bad scan period");
    chk_pd_latch:
        assert property ($fell(pd_en_latch_o) |-> latch_mode_select_strap_i)
        else $error("latch pd off, strap low");
    chk_pd_pol:
        assert property ($fell(pd_en_polarity_o) |-> polarity_select_strap_i)
        else $error("pol pd off, strap low");
    chk_pd_steady:
        assert property (!$rose(pd_en_polarity_o) && !$rose(pd_en_latch_o))
        else $error("pd back on");
endmodule

// file: tksoc_host_pin.sv
/*
 * Host side of the output pin; assumes a line pull-up.
 */
`timescale 1ns/1ps
module tksoc_host_pin (
    input  wire logic drv_i,    // level driven by the block
    input  wire logic drv_en_i, // block drives the pin
    output logic      pin_o     // level the host reads
);
    // a released line floats up through the pull-up
    assign pin_o = drv_en_i ? drv_i : 1'b1;
endmodule

// file: tb_top.sv
/*
 * Touch key bench: straps, scan modes, timeout, apb map.
 * Assumes a short ms tick of TK cycles.
 */
`timescale 1ns/1ps
module tb_top;
    localparam int TK = 2; // cycles per ms tick
    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0;
    logic        pwr = 1'b0, pol = 1'b0, tgl = 1'b0, hit = 1'b0;
    logic [7:0]  padr = 8'h00;
    logic [31:0] pwd = 32'h0, prd;
    logic        prdy, perr, scan, pdp, pdl, dout, doe, pin;
    int          miscompares = 0, total_checks = 0;
    int          cyc = 0, gap = 0, since = 0;
    integer      seed = 29218;

    // 125 MHz clock
    always #4 clk = ~clk;

    tksoc_top #(.TICK_CYCLES(TK)) i_dut (
        .core_clk_i(clk), .reset_i(rst), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(padr), .pwdata_i(pwd), .prdata_o(prd),
        .pready_o(prdy), .pslverr_o(perr), .polarity_select_strap_i(pol),
        .latch_mode_select_strap_i(tgl), .sense_hit_i(hit),
        .scan_start_o(scan), .pd_en_polarity_o(pdp), .pd_en_latch_o(pdl),
        .out_o(dout), .out_oe_o(doe));
    tksoc_host_pin i_host (.drv_i(dout), .drv_en_i(doe), .pin_o(pin));

    // scan period in ms and run limit
    always @(posedge clk) begin
        if (scan) gap = (since + 1) / TK;
        since = scan ? 0 : since + 1;
        if (++cyc > 110000) begin
            miscompares++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %0h vs %0h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input int got, input int lo, input int hi);
        total_checks++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("wrong value at %0t: %0h vs %0h", $time, got, hi);
        end
    endtask

    task automatic ms(input int n);
        repeat (n * TK) @(posedge clk);
    endtask

    // one apb transfer, held until ready
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        @(posedge clk);
        {psel, pwr, padr, pwd} <= {1'b1, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do @(posedge clk);
        while (prdy !== 1'b1 && ++n < 20);
        if (n == 20) miscompares++;
        {r, e} = {prd, perr};
        {psel, pen} <= 2'b00;
    endtask

    function automatic logic exp_pin(input logic od, p, s);
        return od ? ~s : s ^ p;
    endfunction

    task automatic power_on(input logic p, t, input logic [31:0] cfg);
        logic [31:0] r;
        logic        e;
        {rst, pol, tgl, hit} <= {1'b1, p, t, 1'b0};
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, tksoc_pkg::REG_CFG, 32'h0, r, e);
        chk(r, 32'(tksoc_pkg::CFG_RST));
        apb(1'b1, tksoc_pkg::REG_CFG, cfg, r, e);
        apb(1'b0, tksoc_pkg::REG_CFG, 32'h0, r, e);
        chk(r, cfg);
        apb(1'b0, 8'h0C, 32'h0, r, e);
        chk({e, r[30:0]}, 32'h80000000);
    endtask

    // touch at a random phase, time the pin
    task automatic press(input logic e, input int hi);
        int n;
        n = {$random(seed)} % 16;
        ms(n);
        hit <= 1'b1;
        for (n = 0; pin !== e && n < 200 * TK; n++) @(negedge clk);
        chk_rng(n, 34 * TK, hi * TK);
    endtask

    task automatic key_run(input logic od, ns, p, t);
        logic ep, et;
        ep = (od | ns) ? 1'b0 : p;
        et = ns ? 1'b0 : t;
        power_on(p, t, {27'h0, ns, od, 3'h0});
        hit <= 1'b1;
        ms(450);
        hit <= 1'b0;
        chk(32'(pin), 32'(exp_pin(od, ep, 1'b0)));
        ms(70);
        chk({30'h0, pdp, pdl}, {30'h0, ~p, ~t});
        pol <= ~p;
        tgl <= ~t;
        press(exp_pin(od, ep, 1'b1), 53);
        hit <= 1'b0;
        ms(60);
        chk(32'(pin), 32'(exp_pin(od, ep, et)));
        hit <= 1'b1;
        ms(60);
        chk(32'(pin), 32'(exp_pin(od, ep, ~et)));
    endtask

    task automatic slow_run(input logic [1:0] opt, input int per, hi);
        power_on(1'b0, 1'b0, {30'h0, opt});
        ms(8420);
        chk(32'(gap), 32'h10);
        ms(300);
        chk(32'(gap), 32'(per));
        press(1'b1, hi);
        ms(20);
        chk(32'(gap), 32'h10);
    endtask

    initial begin
        int r;
        for (int k = 0; k < 7; k++) begin
            r = $random(seed);
            key_run(k > 3 && (k < 6 || r[0]), k == 6, k < 4 ? k[0] : r[1],
                    k < 4 ? k[1] : (k < 6 ? k[0] : r[2]));
        end
        slow_run(2'h2, 128, 176);
        slow_run(2'h1, 32, 70);
        power_on(1'b0, 1'b0, 32'h0);
        ms(520 + 8200);
        chk(32'(gap), 32'h10);
        press(1'b1, 53);
        ms(15900);
        chk(32'(pin), 32'h1);
        ms(300);
        chk(32'(pin), 32'h0);
        hit <= 1'b0;
        ms(40);
        hit <= 1'b1;
        ms(60);
        chk(32'(pin), 32'h1);
        close_out();
    end
endmodule

bind tksoc_top tksoc_sva #(.TICK_CYCLES(TICK_CYCLES)) i_sva (
    .core_clk_i, .reset_i, .psel_i, .penable_i, .paddr_i, .pready_o,
    .pslverr_o, .polarity_select_strap_i, .latch_mode_select_strap_i,
    .scan_start_o, .pd_en_polarity_o, .pd_en_latch_o, .out_o, .out_oe_o);
